/* File: hdl/sgds_sequencer.sv */
// Gate-drive sequencer with strap or AXI4-Lite configuration for three half-bridges.
// Contract
// - Serial port active only while select low.
// - Serial data output only pulls low.
// - Controller serial clock times sampling and shifting.
// - Strapped variant reuses four serial pins.
// - Straps give gain, current, scheme, threshold.
// - Fault pin reports faults without serial.
// - Eight gate-current settings, register or pin.
// - Drive current for period, then hold.
// - Wait for opposite gate off before on.
// - Serial variant adds programmable digital dead time.
// - Strong pulldown on opposite gate while switching.
// - Strong pulldown lasts drive phase only; a new command during drive keeps it on through turn-off and dead time.
// - Switching command starts gate voltage monitoring.
// - Gate not at threshold at end: fault.
// - New command ends drive period at once.
// - Independent mode holds at drive current.
// - Deglitch PWM inputs against short pulses.
// - Inputs pass short digital delay stage.
// - Turn conducting gate off before other on.
// - Charge-pump undervoltage is a latched fault.
// - Scheme and gain straps latched once.
// - Mode 11b: gates follow inputs independently.
`include "sgds_consts.svh"
module sgds_sequencer #(
  parameter int PHASES = 3
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              serialVariant,
  input  wire logic              serial_select_low,
  input  wire logic              serialClk,
  input  wire logic              serialDataIn,
  output logic                   serialDataOut,
  output logic                   serialDataOutEn,
  input  wire logic [1:0]        strapGain,
  input  wire logic [2:0]        strapCurrent,
  input  wire logic [1:0]        strapMode,
  input  wire logic [2:0]        drain_source_threshold_pin,
  input  wire logic [PHASES-1:0] pwmHigh,
  input  wire logic [PHASES-1:0] pwmLow,
  input  wire logic [PHASES-1:0] gateHighMon,
  input  wire logic [PHASES-1:0] gateLowMon,
  input  wire logic              pumpUnder,
  output sgds_pkg::sgds_gate_type gateOut [PHASES],
  output logic [1:0]             gainOut,
  output logic [2:0]             vdsOut,
  output logic                   fault_out_low,
  output logic                   faultOutEn,
  input  wire logic [7:0]        awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [7:0]        araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready
);
  logic [31:0]        ctrl_q;
  logic [31:0]        drive_q;
  logic [PHASES-1:0]  gdfHigh_q;
  logic [PHASES-1:0]  gdfLow_q;
  logic               cpuv_q;
  logic [2:0]         strapStage_q;
  sgds_pkg::sgds_cfg_type strapSync1_q;
  sgds_pkg::sgds_cfg_type strapSync2_q;
  sgds_pkg::sgds_cfg_type cfg_q;
  logic [7:0]         awaddr_q;
  logic [31:0]        wdata_q;
  logic [3:0]         wstrb_q;
  logic               awHave_q;
  logic               wHave_q;
  logic [1:0]         cpuvSync_q;
  logic [1:0]         selSync_q;
  logic [1:0]         sclkSync_q;
  logic [1:0]         sdiSync_q;
  logic               sclkPrev_q;
  logic [15:0]        shift_q;
  logic               statusClr;
  logic               sdo_q;
  logic [1:0]         pwmMode;
  logic [2:0]         curSel;
  logic [7:0]         tdrvSel;
  logic [7:0]         deadSel;
  logic               writeFire;
  logic [PHASES-1:0]  gdfHighSet;
  logic [PHASES-1:0]  gdfLowSet;

  // Strap latch once after reset release; serial variant uses registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strapStage_q <= 3'h0;
      strapSync1_q <= '0;
      strapSync2_q <= '0;
      cfg_q        <= '0;
    end else begin
      strapSync1_q <= '{strapMode, strapCurrent, strapGain, drain_source_threshold_pin};
      strapSync2_q <= strapSync1_q;
      strapStage_q <= {strapStage_q[1:0], 1'b1};
      if (strapStage_q[1] && !strapStage_q[2]) cfg_q <= strapSync2_q;
    end
  end

  assign pwmMode = serialVariant ? ctrl_q[`SGDS_MODE_LSB +: 2] : cfg_q.pwmMode;
  assign curSel  = serialVariant ? drive_q[`SGDS_IDRV_LSB +: 3] : cfg_q.currentSel;
  assign tdrvSel = drive_q[`SGDS_TDRV_LSB +: 8];
  assign deadSel = serialVariant ? drive_q[`SGDS_DEAD_LSB +: 8] : 8'h00;
  assign gainOut = serialVariant ? ctrl_q[`SGDS_GAIN_LSB +: 2] : cfg_q.gain;
  assign vdsOut  = serialVariant ? ctrl_q[`SGDS_VDS_LSB +: 3] : cfg_q.vdsSel;

  // Serial pins synchronised; shift register only in serial variant.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      selSync_q  <= 2'h3;
      sclkSync_q <= 2'h0;
      sdiSync_q  <= 2'h0;
      cpuvSync_q <= 2'h0;
      sclkPrev_q <= 1'b0;
    end else begin
      selSync_q  <= {selSync_q[0], serial_select_low};
      sclkSync_q <= {sclkSync_q[0], serialClk};
      sdiSync_q  <= {sdiSync_q[0], serialDataIn};
      cpuvSync_q <= {cpuvSync_q[0], pumpUnder};
      sclkPrev_q <= sclkSync_q[1];
    end
  end

  // Status word shifts out on rising edges, input sampled on falling edges.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_q  <= '0;
      sdo_q    <= 1'b1;
    end else if (!serialVariant || selSync_q[1]) begin
      shift_q  <= {8'h00, 1'b0, cpuv_q, gdfLow_q, gdfHigh_q};
      sdo_q    <= 1'b1;
    end else if (sclkSync_q[1] && !sclkPrev_q) begin
      sdo_q    <= shift_q[15];
    end else if (!sclkSync_q[1] && sclkPrev_q) begin
      shift_q  <= {shift_q[14:0], sdiSync_q[1]};
    end
  end

  assign serialDataOut   = 1'b0;
  assign serialDataOutEn = serialVariant && !selSync_q[1] && !sdo_q;

  genvar p;
  generate
    for (p = 0; p < PHASES; p++) begin : g_phase
      logic [1:0] hiSync_q;
      logic [1:0] loSync_q;
      logic [1:0] hiMonSync_q;
      logic [1:0] loMonSync_q;
      logic [3:0] hiCnt_q;
      logic [3:0] loCnt_q;
      logic       hiClean_q;
      logic       loClean_q;
      logic       wantHi_q;
      logic       wantLo_q;
      logic       wantHi;
      logic       wantLo;
      logic       newCmd;
      logic [15:0] timer_q;
      logic       targetHigh_q;
      logic       prevHigh_q;
      logic       prevLow_q;
      sgds_pkg::sgds_state_type state_q;

      // Pins synchronised then held stable for a few cycles before use.
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          hiSync_q  <= 2'h0;
          loSync_q  <= 2'h0;
          hiMonSync_q <= 2'h0;
          loMonSync_q <= 2'h0;
          hiCnt_q   <= '0;
          loCnt_q   <= '0;
          hiClean_q <= 1'b0;
          loClean_q <= 1'b0;
        end else begin
          hiSync_q <= {hiSync_q[0], pwmHigh[p]};
          loSync_q <= {loSync_q[0], pwmLow[p]};
          hiMonSync_q <= {hiMonSync_q[0], gateHighMon[p]};
          loMonSync_q <= {loMonSync_q[0], gateLowMon[p]};
          if (hiSync_q[1] == hiClean_q) hiCnt_q <= '0;
          else if (hiCnt_q == `SGDS_DEGLITCH_CYC) begin
            hiClean_q <= hiSync_q[1];
            hiCnt_q   <= '0;
          end else hiCnt_q <= hiCnt_q + 4'h1;
          if (loSync_q[1] == loClean_q) loCnt_q <= '0;
          else if (loCnt_q == `SGDS_DEGLITCH_CYC) begin
            loClean_q <= loSync_q[1];
            loCnt_q   <= '0;
          end else loCnt_q <= loCnt_q + 4'h1;
        end
      end

      // Mode decode into the wanted gate pair.
      always_comb begin
        case (pwmMode)
          `SGDS_MODE_INDEP: begin
            wantHi = hiClean_q;
            wantLo = loClean_q;
          end
          `SGDS_MODE_3X: begin
            wantHi = loClean_q && hiClean_q;
            wantLo = loClean_q && !hiClean_q;
          end
          default: begin
            wantHi = hiClean_q && !loClean_q;
            wantLo = loClean_q && !hiClean_q;
          end
        endcase
      end

      // One-cycle delay stage between decode and the sequencer.
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          wantHi_q <= 1'b0;
          wantLo_q <= 1'b0;
        end else begin
          wantHi_q <= wantHi;
          wantLo_q <= wantLo;
        end
      end
      assign newCmd = (wantHi_q != prevHigh_q) || (wantLo_q != prevLow_q);

      // Switching sequence: off until both monitors low, dead time, then on for the drive period.
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          state_q      <= sgds_pkg::SGDS_IDLE;
          timer_q      <= '0;
          targetHigh_q <= 1'b0;
          prevHigh_q   <= 1'b0;
          prevLow_q    <= 1'b0;
          gateOut[p]   <= '0;
        end else if (pwmMode == `SGDS_MODE_INDEP) begin
          state_q    <= sgds_pkg::SGDS_IDLE;
          prevHigh_q <= wantHi_q;
          prevLow_q  <= wantLo_q;
          gateOut[p] <= '{curSel, curSel, wantHi_q, wantLo_q, 1'b0, 1'b0};
        end else if (newCmd) begin
          prevHigh_q   <= wantHi_q;
          prevLow_q    <= wantLo_q;
          targetHigh_q <= wantHi_q;
          timer_q      <= 16'(tdrvSel) * 16'(`SGDS_TDRV_UNIT_CYC);
          state_q      <= sgds_pkg::SGDS_TURNOFF;
          gateOut[p].highOn      <= gateOut[p].highOn && wantHi_q;
          gateOut[p].lowOn       <= gateOut[p].lowOn && wantLo_q;
          gateOut[p].highCurrent <= curSel;
          gateOut[p].lowCurrent  <= curSel;
        end else begin
          case (state_q)
            sgds_pkg::SGDS_TURNOFF: begin
              if (!hiMonSync_q[1] && !loMonSync_q[1]) begin
                state_q <= sgds_pkg::SGDS_DEAD;
                timer_q <= {8'h00, deadSel};
              end else if (timer_q != '0) timer_q <= timer_q - 16'h0001;
            end
            sgds_pkg::SGDS_DEAD: begin
              if (timer_q != '0) timer_q <= timer_q - 16'h0001;
              else if (!wantHi_q && !wantLo_q) begin
                state_q                <= sgds_pkg::SGDS_IDLE;
                gateOut[p].highStrong  <= 1'b0;
                gateOut[p].lowStrong   <= 1'b0;
                gateOut[p].highCurrent <= `SGDS_IDRV_HOLD;
                gateOut[p].lowCurrent  <= `SGDS_IDRV_HOLD;
              end else begin
                state_q <= sgds_pkg::SGDS_TURNON;
                timer_q <= 16'(tdrvSel) * 16'(`SGDS_TDRV_UNIT_CYC);
                gateOut[p].highOn     <= targetHigh_q;
                gateOut[p].lowOn      <= !targetHigh_q;
                gateOut[p].highStrong <= !targetHigh_q;
                gateOut[p].lowStrong  <= targetHigh_q;
              end
            end
            sgds_pkg::SGDS_TURNON: begin
              if (timer_q != '0) timer_q <= timer_q - 16'h0001;
              else begin
                state_q <= sgds_pkg::SGDS_IDLE;
                gateOut[p].highStrong  <= 1'b0;
                gateOut[p].lowStrong   <= 1'b0;
                gateOut[p].highCurrent <= `SGDS_IDRV_HOLD;
                gateOut[p].lowCurrent  <= `SGDS_IDRV_HOLD;
              end
            end
            default: state_q <= sgds_pkg::SGDS_IDLE;
          endcase
        end
      end

      // Gate not at threshold when drive period expires.
      assign gdfHighSet[p] = !newCmd && state_q == sgds_pkg::SGDS_TURNON && timer_q == '0
                             && targetHigh_q && !hiMonSync_q[1];
      assign gdfLowSet[p]  = !newCmd && state_q == sgds_pkg::SGDS_TURNON && timer_q == '0
                             && !targetHigh_q && !loMonSync_q[1];
    end
  endgenerate

  // AXI4-Lite write path; address and data taken in either order.
  assign awready   = !awHave_q && !bvalid;
  assign wready    = !wHave_q && !bvalid;
  assign writeFire = awHave_q && wHave_q && !bvalid;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awHave_q <= 1'b0;
      wHave_q  <= 1'b0;
      awaddr_q <= '0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
      bvalid   <= 1'b0;
      bresp    <= `SGDS_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awHave_q <= 1'b1;
        awaddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        wHave_q <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (writeFire) begin
        awHave_q <= 1'b0;
        wHave_q  <= 1'b0;
        bvalid   <= 1'b1;
        bresp    <= (awaddr_q == `SGDS_ADDR_CTRL || awaddr_q == `SGDS_ADDR_DRIVE
                     || awaddr_q == `SGDS_ADDR_STATUS) ? `SGDS_RESP_OKAY : `SGDS_RESP_SLVERR;
      end else if (bready) bvalid <= 1'b0;
    end
  end

  // Configuration registers with byte strobes.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q  <= `SGDS_CTRL_RESET;
      drive_q <= `SGDS_DRIVE_RESET;
    end else if (writeFire) begin
      for (int b = 0; b < 4; b++) begin
        if (wstrb_q[b] && awaddr_q == `SGDS_ADDR_CTRL) ctrl_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
        if (wstrb_q[b] && awaddr_q == `SGDS_ADDR_DRIVE) drive_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
      end
    end
  end

  assign statusClr = writeFire && awaddr_q == `SGDS_ADDR_STATUS && wstrb_q[0];
  // Sticky faults; writing one clears, a new event wins.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gdfHigh_q <= '0;
      gdfLow_q  <= '0;
      cpuv_q    <= 1'b0;
    end else begin
      gdfHigh_q <= (gdfHigh_q & ~(statusClr ? wdata_q[PHASES-1:0] : '0)) | gdfHighSet;
      gdfLow_q  <= (gdfLow_q & ~(statusClr ? wdata_q[PHASES +: PHASES] : '0)) | gdfLowSet;
      cpuv_q    <= (cpuv_q && !(statusClr && wdata_q[2*PHASES])) || cpuvSync_q[1];
    end
  end

  assign fault_out_low = 1'b0;
  assign faultOutEn    = cpuv_q || (|gdfHigh_q) || (|gdfLow_q);

  // AXI4-Lite read path.
  assign arready = !rvalid;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= `SGDS_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp  <= `SGDS_RESP_OKAY;
      case (araddr)
        `SGDS_ADDR_CTRL:   rdata <= ctrl_q;
        `SGDS_ADDR_DRIVE:  rdata <= drive_q;
        `SGDS_ADDR_STATUS: rdata <= 32'({cpuv_q, gdfLow_q, gdfHigh_q});
        `SGDS_ADDR_STRAP:  rdata <= 32'(cfg_q);
        default: begin
          rdata <= '0;
          rresp <= `SGDS_RESP_SLVERR;
        end
      endcase
    end else if (rready) rvalid <= 1'b0;
  end
endmodule

/* File: hdl/sgds_consts.svh */
// Named constants for the gate-drive sequencer.
`ifndef SGDS_CONSTS_SVH
`define SGDS_CONSTS_SVH
`define SGDS_ADDR_CTRL       8'h00
`define SGDS_ADDR_DRIVE      8'h04
`define SGDS_ADDR_STATUS     8'h08
`define SGDS_ADDR_STRAP      8'h0c
`define SGDS_CTRL_RESET      32'h0000_0000
`define SGDS_DRIVE_RESET     32'h0000_1003
`define SGDS_MODE_LSB        0
`define SGDS_IDRV_LSB        0
`define SGDS_TDRV_LSB        4
`define SGDS_DEAD_LSB        12
`define SGDS_GAIN_LSB        4
`define SGDS_VDS_LSB         8
`define SGDS_MODE_INDEP      2'h3
`define SGDS_MODE_3X         2'h1
`define SGDS_IDRV_HOLD       3'h0
`define SGDS_DEGLITCH_CYC    4'h3
`define SGDS_TDRV_UNIT_CYC   8'h10
`define SGDS_RESP_OKAY       2'h0
`define SGDS_RESP_SLVERR     2'h2
`endif

/* File: hdl/sgds_pkg.sv */
// Types shared by the gate-drive sequencer.
package sgds_pkg;
  typedef enum logic [1:0] {SGDS_IDLE, SGDS_TURNOFF, SGDS_DEAD, SGDS_TURNON} sgds_state_type;
  typedef struct packed {
    logic [1:0] pwmMode;
    logic [2:0] currentSel;
    logic [1:0] gain;
    logic [2:0] vdsSel;
  } sgds_cfg_type;
  typedef struct packed {
    logic [2:0] highCurrent;
    logic [2:0] lowCurrent;
    logic       highOn;
    logic       lowOn;
    logic       highStrong;
    logic       lowStrong;
  } sgds_gate_type;
endpackage

/* File: tb/sgds_sequencer_asserts.sv */
// Concurrent checks on the gate-drive sequencer ports.
module sgds_sequencer_asserts #(
  parameter int PHASES = 3
) (
  input wire logic                    clk,
  input wire logic                    rst_n,
  input wire logic                    serialVariant,
  input wire logic                    serial_select_low,
  input wire logic                    serialDataOut,
  input wire logic                    serialDataOutEn,
  input wire logic [1:0]              strapMode,
  input wire logic                    pumpUnder,
  input wire sgds_pkg::sgds_gate_type gateOut [PHASES],
  input wire logic [1:0]              gainOut,
  input wire logic                    faultOutEn,
  input wire logic                    bvalid,
  input wire logic                    bready,
  input wire logic                    rvalid,
  input wire logic                    rready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [2:0] upCnt_q;
  logic       overlap, strongHigh, strongLow;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) upCnt_q <= 3'h0;
    else if (upCnt_q != 3'h7) upCnt_q <= upCnt_q + 3'h1;
  end
  always_comb begin
    overlap = 1'b0;
    strongHigh = 1'b0;
    strongLow = 1'b0;
    for (int i = 0; i < PHASES; i++) begin
      overlap = overlap | (gateOut[i].highOn & gateOut[i].lowOn);
      strongHigh = strongHigh | (gateOut[i].highStrong & gateOut[i].highOn);
      strongLow = strongLow | (gateOut[i].lowStrong & gateOut[i].lowOn);
    end
  end
  a_sdo_low: assert property (!serialDataOut)
    else $error("serial data output driven high");
  a_sdo_release: assert property (serial_select_low [*5] |-> !serialDataOutEn)
    else $error("serial data line held while deselected");
  a_no_shoot: assert property (!serialVariant && strapMode != 2'h3 |-> !overlap)
    else $error("both gates of one bridge on");
  a_strong_high: assert property (!strongHigh)
    else $error("strong pulldown on a high gate that is on");
  a_strong_low: assert property (!strongLow)
    else $error("strong pulldown on a low gate that is on");
  a_pump_fault: assert property (pumpUnder [*4] |-> ##[0:4] faultOutEn)
    else $error("pump undervoltage not on fault pin");
  a_b_once: assert property (bvalid && bready |=> !bvalid)
    else $error("write response repeated");
  a_r_once: assert property (rvalid && rready |=> !rvalid)
    else $error("read response repeated");
  a_strap_hold: assert property (&upCnt_q && !serialVariant |-> $stable(gainOut))
    else $error("latched gain strap changed");
  c_strong: cover property (gateOut[0].highOn && gateOut[0].lowStrong);
  c_fault: cover property ($rose(faultOutEn));
  c_read: cover property (rvalid && rready);
endmodule

bind sgds_sequencer sgds_sequencer_asserts #(.PHASES(PHASES)) u_sgds_sequencer_asserts (
  .clk, .rst_n, .serialVariant, .serial_select_low, .serialDataOut, .serialDataOutEn,
  .strapMode, .pumpUnder, .gateOut, .gainOut, .faultOutEn, .bvalid, .bready, .rvalid, .rready
);

/* File: tb/sgds_gate_model.sv */
// Gate-voltage monitors of the external bridge MOSFETs.
module sgds_gate_model #(
  parameter int PHASES = 3,
  parameter int DELAY  = 6
) (
  input  wire logic                    clk,
  input  wire sgds_pkg::sgds_gate_type gateOut [PHASES],
  input  wire logic [PHASES-1:0]       stuckLow,
  output logic [PHASES-1:0]            gateHighMon,
  output logic [PHASES-1:0]            gateLowMon
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [PHASES-1:0] hiPipe [DELAY];
  logic [PHASES-1:0] loPipe [DELAY];
  // Gate charge ends well inside the drive period.
  always @(posedge clk) begin
    for (int p = 0; p < PHASES; p++) begin
      hiPipe[0][p] <= gateOut[p].highOn;
      loPipe[0][p] <= gateOut[p].lowOn;
    end
    for (int k = 1; k < DELAY; k++) begin
      hiPipe[k] <= hiPipe[k-1];
      loPipe[k] <= loPipe[k-1];
    end
  end
  // A stuck gate never reaches its threshold.
  assign gateHighMon = hiPipe[DELAY-1] & ~stuckLow;
  assign gateLowMon  = loPipe[DELAY-1] & ~stuckLow;
endmodule

/* File: tb/sgds_sequencer_tb.sv */
// Self-checking bench for the gate-drive sequencer.
`include "sgds_consts.svh"
module sgds_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    clk = 1'b0, rst_n = 1'b0, serialVariant = 1'b0, pumpUnder = 1'b0;
  logic                    serial_select_low = 1'b1, serialClk = 1'b0, serialDataIn = 1'b0;
  logic                    awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic                    arvalid = 1'b0, rready = 1'b0;
  logic [1:0]              strapGain = 2'h0, strapMode = 2'h0, bresp, rresp, gainOut;
  logic [2:0]              strapCurrent = 3'h5, vdsPin = 3'h0, vdsOut, stuck = 3'h0;
  logic [2:0]              pwmHigh = 3'h0, pwmLow = 3'h0, gateHighMon, gateLowMon;
  logic [7:0]              awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]             wdata = 32'h0, rdata;
  logic [33:0]             expE;
  logic [33:0]             expQ [$];
  logic                    serialDataOut, serialDataOutEn, fault_out_low, faultOutEn;
  logic                    awready, wready, bvalid, arready, rvalid;
  sgds_pkg::sgds_gate_type gateOut [3];
  int                      seed = 52, fail_count = 0, check_count = 0;

  always #2 clk = ~clk;

  sgds_sequencer u_sgds_sequencer (
    .clk, .rst_n, .serialVariant, .serial_select_low, .serialClk, .serialDataIn,
    .serialDataOut, .serialDataOutEn, .strapGain, .strapCurrent, .strapMode,
    .drain_source_threshold_pin(vdsPin), .pwmHigh, .pwmLow, .gateHighMon, .gateLowMon,
    .pumpUnder, .gateOut, .gainOut, .vdsOut, .fault_out_low, .faultOutEn, .awaddr,
    .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready
  );
  sgds_gate_model u_sgds_gate_model (
    .clk, .gateOut, .stuckLow(stuck), .gateHighMon, .gateLowMon
  );

  task automatic test_done();
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (e !== s) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tmo(input string nm);
    chk(nm, 32'h0, 32'h1);
    test_done();
  endtask
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    expQ.push_back({32'h0, r});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    bready <= 1'b0;
    if (n == 50) tmo("write wait");
    @(posedge clk);
  endtask
  task automatic axiRead(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    expQ.push_back({d, r});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    rready <= 1'b0;
    if (n == 50) tmo("read wait");
    @(posedge clk);
  endtask
  task automatic waitOn(input int p, input bit hi, input logic v);
    int n;
    n = 0;
    while ((hi ? gateOut[p].highOn : gateOut[p].lowOn) !== v && n < 200) begin
      @(posedge clk);
      n++;
    end
    if (n == 200) tmo("gate wait");
  endtask
  task automatic doReset(input logic sv);
    rst_n <= 1'b0;
    serialVariant <= sv;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  always @(posedge clk) begin
    if ((bvalid && bready) || (rvalid && rready)) begin
      expE = expQ.pop_front();
      if (rvalid) chk("rdata", expE[33:2], rdata);
      chk("resp", {30'h0, expE[1:0]}, {30'h0, rvalid ? rresp : bresp});
    end
  end

  initial begin
    strapGain <= 2'($random(seed));
    vdsPin <= 3'({$random(seed)} % 7);
    doReset(1'b0);
    chk("gain", strapGain, gainOut);
    chk("vds", vdsPin, vdsOut);
    strapGain <= ~strapGain;
    repeat (3) @(posedge clk);
    chk("gain hold", 2'(~strapGain), gainOut);
    axiRead(`SGDS_ADDR_DRIVE, `SGDS_DRIVE_RESET, `SGDS_RESP_OKAY);
    axiRead(`SGDS_ADDR_CTRL, `SGDS_CTRL_RESET, `SGDS_RESP_OKAY);
    axiWrite(8'h10, 32'h0, `SGDS_RESP_SLVERR);
    axiRead(8'h10, 32'h0, `SGDS_RESP_SLVERR);
    axiWrite(`SGDS_ADDR_DRIVE, 32'h0000_0025, `SGDS_RESP_OKAY);
    axiRead(`SGDS_ADDR_DRIVE, 32'h0000_0025, `SGDS_RESP_OKAY);
    pwmHigh[0] <= 1'b1;
    waitOn(0, 1, 1'b1);
    chk("drive cur", strapCurrent, gateOut[0].highCurrent);
    chk("strong on", 1'b1, gateOut[0].lowStrong);
    repeat (40) @(posedge clk);
    chk("hold cur", `SGDS_IDRV_HOLD, gateOut[0].highCurrent);
    chk("strong off", 1'b0, gateOut[0].lowStrong);
    pwmLow[0] <= 1'b1;
    repeat (2) @(posedge clk);
    pwmLow[0] <= 1'b0;
    repeat (20) @(posedge clk);
    chk("glitch", 1'b1, gateOut[0].highOn);
    pwmHigh[0] <= 1'b0;
    pwmLow[0] <= 1'b1;
    repeat (3) @(posedge clk);
    chk("delay", 1'b1, gateOut[0].highOn);
    waitOn(0, 0, 1'b1);
    chk("high mon", 1'b0, gateHighMon[0]);
    chk("high off", 1'b0, gateOut[0].highOn);
    stuck[1] <= 1'b1;
    pwmHigh[1] <= 1'b1;
    waitOn(1, 1, 1'b1);
    repeat (40) @(posedge clk);
    chk("gate fault", 1'b1, faultOutEn);
    chk("fault pin", 1'b0, fault_out_low);
    stuck[1] <= 1'b0;
    axiRead(`SGDS_ADDR_STATUS, 32'h0000_0002, `SGDS_RESP_OKAY);
    axiWrite(`SGDS_ADDR_STATUS, 32'h0000_007f, `SGDS_RESP_OKAY);
    axiRead(`SGDS_ADDR_STATUS, 32'h0, `SGDS_RESP_OKAY);
    chk("fault clr", 1'b0, faultOutEn);
    pumpUnder <= 1'b1;
    repeat (10) @(posedge clk);
    pumpUnder <= 1'b0;
    axiRead(`SGDS_ADDR_STATUS, 32'h0000_0040, `SGDS_RESP_OKAY);
    axiWrite(`SGDS_ADDR_STATUS, 32'h0000_0040, `SGDS_RESP_OKAY);
    axiRead(`SGDS_ADDR_STATUS, 32'h0, `SGDS_RESP_OKAY);
    doReset(1'b1);
    axiWrite(`SGDS_ADDR_CTRL, 32'h0000_0523, `SGDS_RESP_OKAY);
    chk("reg gain", 2'h2, gainOut);
    chk("reg vds", 3'h5, vdsOut);
    axiWrite(`SGDS_ADDR_DRIVE, 32'h0000_4026, `SGDS_RESP_OKAY);
    pwmHigh[2] <= 1'b1;
    pwmLow[2] <= 1'b1;
    waitOn(2, 1, 1'b1);
    waitOn(2, 0, 1'b1);
    repeat (40) @(posedge clk);
    chk("indep on", 1'b1, gateOut[2].highOn);
    chk("indep cur", 3'h6, gateOut[2].highCurrent);
    serial_select_low <= 1'b0;
    repeat (16) begin
      repeat (4) @(posedge clk);
      serialClk <= ~serialClk;
      serialDataIn <= 1'($random(seed));
    end
    repeat (4) @(posedge clk);
    chk("sdo pull", 1'b1, serialDataOutEn);
    serial_select_low <= 1'b1;
    repeat (10) @(posedge clk);
    chk("sdo free", 1'b0, serialDataOutEn);
    test_done();
  end
endmodule
